// *** include/smp_pkg.sv ***
package smp_pkg;

   // internal data bus width and the bit of each pin on it
   localparam int BUS_W = 8;
   localparam int BIT_MOSI = 3;
   localparam int BIT_SCK = 4;

   // synchroniser depth for anything arriving from another domain
   localparam int SYNC_STAGES = 3;

   // reset values
   localparam logic DIR_RST = 1'h0;
   localparam logic LATCH_RST = 1'h0;
   localparam logic [BUS_W-1:0] RDATA_RST = 8'h00;
   localparam logic FLAG_RST = 1'h0;

   // index of each bit in the core-side synchroniser bundle
   localparam int CS_MDO = 0;
   localparam int CS_MSCK = 1;
   localparam int CS_MACT = 2;
   localparam int CS_MOSI = 3;
   localparam int CS_SCK = 4;
   localparam int CS_SSN = 5;
   localparam int CS_W = 6;

   // index of each bit in the link-side synchroniser bundle
   localparam int LS_MOSI = 0;
   localparam int LS_SCK = 1;
   localparam int LS_W = 2;

   // one bit for each of the two pins
   typedef struct packed {
      logic mosi;
      logic sck;
   } smp_pair_t;

   // drive of one pin: level and output enable
   typedef struct packed {
      logic out;
      logic oe;
   } smp_drive_t;

   // state kept on the core clock
   typedef struct packed {
      smp_pair_t dir;
      smp_pair_t latch;
      smp_drive_t mosiPin;
      smp_drive_t sckPin;
      logic [BUS_W-1:0] readData;
      logic readValid;
      logic modeFault;
   } smp_core_t;

   // state kept on the spi core clock
   typedef struct packed {
      logic slaveDataIn;
      logic slaveClockIn;
   } smp_link_t;

endpackage

// *** core/smp_sync3.sv ***
`timescale 1ns/1ps
// three-stage synchroniser; output follows once stages two and three agree
module smp_sync3 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } smp_sync_state_t;

   smp_sync_state_t st_r;
   smp_sync_state_t st_nxt;

   // first stage is read only by the second; the filter looks at 2 and 3
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.q = (~(st_r.s2 ^ st_r.s3) & st_r.s2)
               | ((st_r.s2 ^ st_r.s3) & st_r.q);
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.q;

endmodule

// *** core/smp_pin_logic.sv ***
`timescale 1ns/1ps
// Behaviour
// R1 - direction write strobe loads both direction bits from the data bus
// R2 - direction read strobe returns both stored direction bits on the bus
// R3 - reset clears both direction bits, leaving the pins as inputs
// R4 - mode fault clears both direction bits at once, pins become inputs
// R5 - fault is a master being selected as a slave from outside
// R6 - spi off or master: driver enabled exactly when direction bit is one
// R7 - spi on as slave: both drivers off whatever the direction bits
// R8 - master software sets data-out direction bit before data can leave
// R9 - master software sets clock direction bit before the clock appears
// R10 - wired-or mode: a one is never driven, the pin floats instead
// R11 - data-out pin takes spi master data when enabled, else port latch
// R12 - clock pin takes spi master clock when enabled, else port latch
// R13 - port write strobe loads both output latches from the data bus
// R14 - port read gives driven value if driver on, else pin level
// R15 - data-out pin level always feeds the spi slave data input
// R16 - clock pin level feeds slave clock input, ignored while master
// R17 - slave select detects faults in master only while its direction is 0
// R18 - output latches come out of reset at zero
module smp_pin_logic (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic spiCoreClk,
   input wire logic [smp_pkg::BUS_W-1:0] dataBusIn,
   input wire logic directionWriteStrobe,
   input wire logic directionReadStrobe,
   input wire logic portWriteStrobe,
   input wire logic portReadStrobe,
   input wire logic spiSystemEnable,
   input wire logic masterModeSelect,
   input wire logic wiredOrMode,
   input wire logic slaveSelectDirBit,
   input wire logic masterActive,
   input wire logic masterSerialDataOut,
   input wire logic masterSerialClockOut,
   input wire logic portPinThreeIn,
   input wire logic portPinFourIn,
   input wire logic slaveSelectPinN,
   output logic portPinThreeOut,
   output logic portPinThreeOe,
   output logic portPinFourOut,
   output logic portPinFourOe,
   output logic [smp_pkg::BUS_W-1:0] readData,
   output logic readValid,
   output logic modeFault,
   output logic slaveSerialDataIn,
   output logic slaveClockIn
);

   smp_pkg::smp_core_t st_r;
   smp_pkg::smp_core_t st_nxt;
   smp_pkg::smp_link_t lk_r;
   smp_pkg::smp_link_t lk_nxt;

   logic [smp_pkg::CS_W-1:0] coreRaw;
   logic [smp_pkg::CS_W-1:0] coreSync;
   logic [smp_pkg::LS_W-1:0] linkRaw;
   logic [smp_pkg::LS_W-1:0] linkSync;

   logic mdoS;
   logic msckS;
   logic mactS;
   logic mosiLvl;
   logic sckLvl;
   logic ssLowS;
   logic faultNow;
   logic slaveHold;
   logic mosiDrv;
   logic sckDrv;
   logic mosiVal;
   logic sckVal;
   logic busMosiBit;
   logic busSckBit;

   // everything from the spi core clock or from pins is filtered here
   assign coreRaw[smp_pkg::CS_MDO] = masterSerialDataOut;
   assign coreRaw[smp_pkg::CS_MSCK] = masterSerialClockOut;
   assign coreRaw[smp_pkg::CS_MACT] = masterActive;
   assign coreRaw[smp_pkg::CS_MOSI] = portPinThreeIn;
   assign coreRaw[smp_pkg::CS_SCK] = portPinFourIn;
   assign coreRaw[smp_pkg::CS_SSN] = ~slaveSelectPinN; // reset 0 = idle

   smp_sync3 #(
      .W(smp_pkg::CS_W)
   ) u_coreSync (
      .clk(core_clk),
      .rstN(arst_n),
      .d(coreRaw),
      .q(coreSync)
   );

   // pins seen again on the spi clock, for the slave inputs
   assign linkRaw[smp_pkg::LS_MOSI] = portPinThreeIn;
   assign linkRaw[smp_pkg::LS_SCK] = portPinFourIn;

   smp_sync3 #(
      .W(smp_pkg::LS_W)
   ) u_linkSync (
      .clk(spiCoreClk),
      .rstN(arst_n),
      .d(linkRaw),
      .q(linkSync)
   );

   // named views of the filtered bundle and of the two data bus bits
   assign mdoS = coreSync[smp_pkg::CS_MDO];
   assign msckS = coreSync[smp_pkg::CS_MSCK];
   assign mactS = coreSync[smp_pkg::CS_MACT];
   assign mosiLvl = coreSync[smp_pkg::CS_MOSI];
   assign sckLvl = coreSync[smp_pkg::CS_SCK];
   assign ssLowS = coreSync[smp_pkg::CS_SSN];
   assign busMosiBit = dataBusIn[smp_pkg::BIT_MOSI];
   assign busSckBit = dataBusIn[smp_pkg::BIT_SCK];

   // select pin only counts as an input while its direction bit is zero
   assign faultNow = spiSystemEnable & masterModeSelect // R5
                   & ~slaveSelectDirBit & ssLowS; // R17

   // slave operation takes the drivers away from the direction bits
   assign slaveHold = spiSystemEnable & ~mactS; // R7

   // fault gates the drivers in the same cycle it is seen, not a cycle later
   assign mosiDrv = st_r.dir.mosi & ~slaveHold & ~faultNow; // R6
   assign sckDrv = st_r.dir.sck & ~slaveHold & ~faultNow; // R6

   // data source for each driver
   assign mosiVal = spiSystemEnable ? mdoS : st_r.latch.mosi; // R11
   assign sckVal = spiSystemEnable ? msckS : st_r.latch.sck; // R12

   // core clock next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.modeFault = faultNow;
      // fault beats a write in the same cycle so the lines stay released
      if (faultNow) begin
         st_nxt.dir.mosi = smp_pkg::DIR_RST; // R4
         st_nxt.dir.sck = smp_pkg::DIR_RST; // R4
      end else if (directionWriteStrobe) begin
         st_nxt.dir.mosi = busMosiBit; // R1
         st_nxt.dir.sck = busSckBit; // R1
      end
      if (portWriteStrobe) begin
         st_nxt.latch.mosi = busMosiBit; // R13
         st_nxt.latch.sck = busSckBit; // R13
      end
      // wired-or: a one floats and leans on the external pullup
      st_nxt.mosiPin.out = mosiVal;
      st_nxt.mosiPin.oe = mosiDrv & ~(wiredOrMode & mosiVal); // R10
      st_nxt.sckPin.out = sckVal;
      st_nxt.sckPin.oe = sckDrv & ~(wiredOrMode & sckVal); // R10
      // only the two bits of this block; other lanes read as zero
      st_nxt.readData = smp_pkg::RDATA_RST;
      st_nxt.readValid = portReadStrobe | directionReadStrobe;
      if (portReadStrobe) begin
         st_nxt.readData[smp_pkg::BIT_MOSI] =
            mosiDrv ? mosiVal : mosiLvl; // R14
         st_nxt.readData[smp_pkg::BIT_SCK] =
            sckDrv ? sckVal : sckLvl; // R14
      end else if (directionReadStrobe) begin
         st_nxt.readData[smp_pkg::BIT_MOSI] = st_r.dir.mosi; // R2
         st_nxt.readData[smp_pkg::BIT_SCK] = st_r.dir.sck; // R2
      end
   end

   // core clock registers; reset leaves both pins as inputs
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r.dir <= '{smp_pkg::DIR_RST, smp_pkg::DIR_RST}; // R3
         st_r.latch <= '{smp_pkg::LATCH_RST, smp_pkg::LATCH_RST}; // R18
         st_r.mosiPin <= '{smp_pkg::LATCH_RST, smp_pkg::DIR_RST};
         st_r.sckPin <= '{smp_pkg::LATCH_RST, smp_pkg::DIR_RST};
         st_r.readData <= smp_pkg::RDATA_RST;
         st_r.readValid <= smp_pkg::FLAG_RST;
         st_r.modeFault <= smp_pkg::FLAG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // spi clock next state; masterActive is native to this domain
   always_comb begin
      lk_nxt = lk_r;
      lk_nxt.slaveDataIn = linkSync[smp_pkg::LS_MOSI]; // R15
      // master makes its own clock, so the pin copy is held quiet
      lk_nxt.slaveClockIn =
         masterActive ? 1'h0 : linkSync[smp_pkg::LS_SCK]; // R16
   end

   always_ff @(posedge spiCoreClk or negedge arst_n) begin
      if (!arst_n) begin
         lk_r <= '0;
      end else begin
         lk_r <= lk_nxt;
      end
   end

   // outputs, each straight from a flip-flop
   assign portPinThreeOut = st_r.mosiPin.out;
   assign portPinThreeOe = st_r.mosiPin.oe;
   assign portPinFourOut = st_r.sckPin.out;
   assign portPinFourOe = st_r.sckPin.oe;
   assign readData = st_r.readData;
   assign readValid = st_r.readValid;
   assign modeFault = st_r.modeFault;
   assign slaveSerialDataIn = lk_r.slaveDataIn;
   assign slaveClockIn = lk_r.slaveClockIn;

   // a write without a fault is seen in the stored bits next cycle
   property p_dirLoad; // R1
      @(posedge core_clk) disable iff (!arst_n)
      directionWriteStrobe && !faultNow
      |=> st_r.dir.mosi == $past(busMosiBit)
          && st_r.dir.sck == $past(busSckBit);
   endproperty
   a_dirLoad: assert property (p_dirLoad) // R1
      else $error("direction bits not loaded by write");

   // direction read alone returns the bits held at the strobe
   property p_dirRead; // R2
      @(posedge core_clk) disable iff (!arst_n)
      directionReadStrobe && !portReadStrobe
      |=> readValid
          && readData[smp_pkg::BIT_MOSI] == $past(st_r.dir.mosi)
          && readData[smp_pkg::BIT_SCK] == $past(st_r.dir.sck);
   endproperty
   a_dirRead: assert property (p_dirRead) // R2
      else $error("direction read returned wrong bits");

   // a fault releases both pins and clears the bits on the next edge
   property p_faultClear; // R4
      @(posedge core_clk) disable iff (!arst_n)
      faultNow
      |=> !st_r.dir.mosi && !st_r.dir.sck
          && !portPinThreeOe && !portPinFourOe && modeFault;
   endproperty
   a_faultClear: assert property (p_faultClear) // R4
      else $error("mode fault did not release the pins");

   // a master selected from outside while the select is an input
   property p_faultCause; // R5
      @(posedge core_clk) disable iff (!arst_n)
      spiSystemEnable && masterModeSelect && ssLowS
      |=> modeFault == !$past(slaveSelectDirBit);
   endproperty
   a_faultCause: assert property (p_faultCause) // R5
      else $error("mode fault flag disagrees with its cause");

   // spi off and wired-or off: driver follows the direction bit
   property p_offDrive; // R6
      @(posedge core_clk) disable iff (!arst_n)
      !spiSystemEnable && !wiredOrMode && !faultNow
      |=> portPinThreeOe == $past(st_r.dir.mosi)
          && portPinFourOe == $past(st_r.dir.sck);
   endproperty
   a_offDrive: assert property (p_offDrive) // R6
      else $error("driver does not follow direction with spi off");

   // slave operation keeps both drivers off for as long as it lasts
   property p_slaveOff; // R7
      @(posedge core_clk) disable iff (!arst_n)
      (spiSystemEnable && !mactS) [*2]
      |=> !portPinThreeOe && !portPinFourOe;
   endproperty
   a_slaveOff: assert property (p_slaveOff) // R7
      else $error("pin driven during slave operation");

   // wired-or never drives a one on either pin
   property p_wiredOr; // R10
      @(posedge core_clk) disable iff (!arst_n)
      $past(wiredOrMode)
      |-> !(portPinThreeOe && portPinThreeOut)
          && !(portPinFourOe && portPinFourOut);
   endproperty
   a_wiredOr: assert property (p_wiredOr) // R10
      else $error("wired-or pin driven high");

   // data-out pin carries the master data while spi is enabled
   property p_mosiSrc; // R11
      @(posedge core_clk) disable iff (!arst_n)
      spiSystemEnable |=> portPinThreeOut == $past(mdoS);
   endproperty
   a_mosiSrc: assert property (p_mosiSrc) // R11
      else $error("data-out pin not from master data");

   // clock pin carries the port latch while spi is disabled
   property p_sckSrc; // R12
      @(posedge core_clk) disable iff (!arst_n)
      !spiSystemEnable |=> portPinFourOut == $past(st_r.latch.sck);
   endproperty
   a_sckSrc: assert property (p_sckSrc) // R12
      else $error("clock pin not from port latch");

   // data-out pin carries the port latch while spi is disabled
   property p_mosiLatch; // R11
      @(posedge core_clk) disable iff (!arst_n)
      !spiSystemEnable |=> portPinThreeOut == $past(st_r.latch.mosi);
   endproperty
   a_mosiLatch: assert property (p_mosiLatch) // R11
      else $error("data-out pin not from port latch");

   // clock pin carries the master clock while spi is enabled
   property p_sckSpi; // R12
      @(posedge core_clk) disable iff (!arst_n)
      spiSystemEnable |=> portPinFourOut == $past(msckS);
   endproperty
   a_sckSpi: assert property (p_sckSpi) // R12
      else $error("clock pin not from master clock");

   // a port write reaches the pin two edges later with spi off
   property p_portWrite; // R13
      @(posedge core_clk) disable iff (!arst_n)
      portWriteStrobe ##1 !spiSystemEnable
      |=> portPinThreeOut == $past(busMosiBit, 2);
   endproperty
   a_portWrite: assert property (p_portWrite) // R13
      else $error("port write not latched");

   // undriven pin reads back its filtered level
   property p_portRead; // R14
      @(posedge core_clk) disable iff (!arst_n)
      portReadStrobe && !mosiDrv
      |=> readValid && readData[smp_pkg::BIT_MOSI] == $past(mosiLvl);
   endproperty
   a_portRead: assert property (p_portRead) // R14
      else $error("port read of input pin wrong");

   // driven pin reads back the value sent to the driver
   property p_portDriven; // R14
      @(posedge core_clk) disable iff (!arst_n)
      portReadStrobe && mosiDrv
      |=> readValid && readData[smp_pkg::BIT_MOSI] == $past(mosiVal);
   endproperty
   a_portDriven: assert property (p_portDriven) // R14
      else $error("port read of driven pin wrong");

   // slave data input follows the filtered pin with no direction gating
   property p_slaveData; // R15
      @(posedge spiCoreClk) disable iff (!arst_n)
      1'h1 |=> slaveSerialDataIn == $past(linkSync[smp_pkg::LS_MOSI]);
   endproperty
   a_slaveData: assert property (p_slaveData) // R15
      else $error("slave data input not from pin");

   // while master the slave clock input stays low
   property p_slaveClk; // R16
      @(posedge spiCoreClk) disable iff (!arst_n)
      masterActive |=> !slaveClockIn;
   endproperty
   a_slaveClk: assert property (p_slaveClk) // R16
      else $error("slave clock passed through while master");

endmodule

// *** sim/smp_far_end.sv ***
`timescale 1ns/1ps
// far-side spi party plus the board pullups on the shared lines
module smp_far_end (
   input wire logic pin3Out,
   input wire logic pin3Oe,
   input wire logic pin4Out,
   input wire logic pin4Oe,
   input wire logic [1:0] extEn,
   input wire logic [1:0] extVal,
   input wire logic selLow,
   output logic pin3,
   output logic pin4,
   output logic selN
);
   // released lines settle at the pullup level, never the last value
   always_comb begin
      pin3 = pin3Oe ? pin3Out : (extEn[0] ? extVal[0] : 1'h1);
      pin4 = pin4Oe ? pin4Out : (extEn[1] ? extVal[1] : 1'h1);
      selN = selLow ? 1'h0 : 1'h1;
   end
endmodule

// *** sim/smp_pin_logic_tb.sv ***
`timescale 1ns/1ps
module smp_pin_logic_tb;
   logic core_clk = 1'h0;
   logic spiClk = 1'h0;
   logic arst_n = 1'h0;
   logic [7:0] bus, rdata, v, oe2, out2, slv;
   logic dw, dr, pw, pr, spi_system_enable, mms, wom, ssDir, mAct, mDo, mSck, selLow;
   logic [1:0] extEn, extVal;
   logic p3o, p3e, p4o, p4e, rvalid, mf, sdi, sci, pin3, pin4, selN;
   int err_count = 0;
   int checks = 0;

   // clocks: spi clock offset by 3 ns so the two never share an edge
   always #5 core_clk = ~core_clk;
   initial begin
      #3;
      forever #40 spiClk = ~spiClk;
   end

   assign oe2 = {6'h00, p4e, p3e};
   assign out2 = {6'h00, p4o, p3o};
   assign slv = {6'h00, sci, sdi};

   smp_pin_logic i_smp_pin_logic (.core_clk(core_clk), .arst_n(arst_n),
      .spiCoreClk(spiClk), .dataBusIn(bus), .directionWriteStrobe(dw),
      .directionReadStrobe(dr), .portWriteStrobe(pw),
      .portReadStrobe(pr), .spiSystemEnable(spi_system_enable),
      .masterModeSelect(mms), .wiredOrMode(wom),
      .slaveSelectDirBit(ssDir), .masterActive(mAct),
      .masterSerialDataOut(mDo), .masterSerialClockOut(mSck),
      .portPinThreeIn(pin3), .portPinFourIn(pin4),
      .slaveSelectPinN(selN), .portPinThreeOut(p3o),
      .portPinThreeOe(p3e), .portPinFourOut(p4o), .portPinFourOe(p4e),
      .readData(rdata), .readValid(rvalid), .modeFault(mf),
      .slaveSerialDataIn(sdi), .slaveClockIn(sci));

   smp_far_end i_smp_far_end (.pin3Out(p3o), .pin3Oe(p3e),
      .pin4Out(p4o), .pin4Oe(p4e), .extEn(extEn), .extVal(extVal),
      .selLow(selLow), .pin3(pin3), .pin4(pin4), .selN(selN));

   task automatic chk(input string nm, input logic [7:0] exp,
         input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask

   // one-cycle strobe, then let pins settle through two registers
   task automatic wr(input bit dir, input logic [7:0] d);
      @(posedge core_clk);
      bus <= d;
      if (dir) dw <= 1'h1;
      else pw <= 1'h1;
      @(posedge core_clk);
      dw <= 1'h0;
      pw <= 1'h0;
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   // data lands one edge after the strobe edge
   task automatic rd(input bit dir);
      @(posedge core_clk);
      if (dir) dr <= 1'h1;
      else pr <= 1'h1;
      @(posedge core_clk);
      dr <= 1'h0;
      pr <= 1'h0;
      #1;
      chk("readValid", 8'h01, {7'h00, rvalid});
      v = rdata;
   endtask

   // controls reach the pins one register later; margin for the syncs
   task automatic cfg(input logic [3:0] c);
      @(posedge core_clk);
      {spi_system_enable, mms, wom, ssDir} <= c;
      repeat (8) @(posedge core_clk);
      #1;
   endtask

   task automatic spi(input logic a, input logic d, input logic k);
      @(posedge spiClk);
      mAct <= a;
      mDo <= d;
      mSck <= k;
      repeat (12) @(posedge core_clk);
      #1;
   endtask

   task automatic ext(input logic [1:0] en, input logic [1:0] val);
      @(posedge core_clk);
      extEn <= en;
      extVal <= val;
      repeat (8) @(posedge spiClk);
      #1;
   endtask

   task automatic t_reset;
      chk("oe", 8'h00, oe2);
      rd(1);
      chk("dir", 8'h00, v);
      rd(0);
      chk("port", 8'h18, v);
      $display("t_reset done");
   endtask

   task automatic t_dir;
      wr(1, 8'hFF);
      rd(1);
      chk("dir", 8'h18, v);
      chk("oe", 8'h03, oe2);
      chk("out", 8'h00, out2);
      wr(1, 8'h08);
      chk("oe", 8'h01, oe2);
      $display("t_dir done");
   endtask

   task automatic t_port;
      wr(1, 8'h18);
      wr(0, 8'h08);
      chk("out", 8'h01, out2);
      rd(0);
      chk("port", 8'h08, v);
      wr(1, 8'h00);
      ext(2'h1, 2'h0);
      rd(0);
      chk("port", 8'h10, v);
      ext(2'h0, 2'h0);
      $display("t_port done");
   endtask

   task automatic t_wor;
      wr(1, 8'h18);
      cfg(4'h2);
      chk("oe", 8'h02, oe2);
      cfg(4'h0);
      $display("t_wor done");
   endtask

   task automatic t_master;
      wr(1, 8'h18);
      cfg(4'hC);
      spi(1'h1, 1'h1, 1'h0);
      chk("oe", 8'h03, oe2);
      chk("out", 8'h01, out2);
      spi(1'h1, 1'h0, 1'h1);
      chk("out", 8'h02, out2);
      repeat (8) @(posedge spiClk);
      chk("slave", 8'h00, slv);
      $display("t_master done");
   endtask

   task automatic t_slave;
      cfg(4'h8);
      spi(1'h0, 1'h0, 1'h0);
      chk("oe", 8'h00, oe2);
      ext(2'h3, 2'h3);
      chk("slave", 8'h03, slv);
      ext(2'h3, 2'h1);
      chk("slave", 8'h01, slv);
      ext(2'h0, 2'h0);
      $display("t_slave done");
   endtask

   task automatic t_fault;
      int n;
      cfg(4'hD);
      spi(1'h1, 1'h0, 1'h0);
      wr(1, 8'h18);
      @(posedge core_clk);
      selLow <= 1'h1;
      repeat (10) @(posedge core_clk);
      chk("fault", 8'h00, {7'h00, mf});
      chk("oe", 8'h03, oe2);
      @(posedge core_clk);
      ssDir <= 1'h0;
      n = 0;
      while (mf !== 1'h1 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      #1;
      chk("fault", 8'h01, {7'h00, mf});
      chk("oe", 8'h00, oe2);
      @(posedge core_clk);
      selLow <= 1'h0;
      repeat (8) @(posedge core_clk);
      rd(1);
      chk("dir", 8'h00, v);
      $display("t_fault done");
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // hang guard: the whole sequence needs well under a tenth of this
   initial begin
      #200000;
      err_count++;
      test_done();
   end

   initial begin
      bus = 8'h00;
      {dw, dr, pw, pr, spi_system_enable, mms, wom, ssDir} = 8'h00;
      {mAct, mDo, mSck, selLow} = 4'h0;
      extEn = 2'h0;
      extVal = 2'h0;
      repeat (20) @(posedge core_clk);
      arst_n <= 1'h1;
      repeat (8) @(posedge core_clk);
      t_reset();
      t_dir();
      t_port();
      t_wor();
      t_master();
      t_slave();
      t_fault();
      test_done();
   end
endmodule
